// *** design/phase_monitor_pkg.sv ***
// Package for the line-to-system phase monitor: register map, field layout, reset values.
// Assumes an 8-bit register port with byte offsets as printed.
package phase_monitor_pkg;
  localparam logic [7:0] phase_word_low_offset  = 8'h0e;
  localparam logic [7:0] phase_word_high_offset = 8'h0f;
  localparam int         position_width         = 8;
  localparam int         slot_lsb               = 3;
  localparam int         quadrant_lsb           = 6;
  localparam logic [1:0] quadrant_first         = 2'h0;
  localparam logic [1:0] quadrant_last          = 2'h3;
  localparam logic [7:0] position_reset         = 8'h00;
  localparam logic [8:0] phase_word_reset       = 9'h000;
  localparam logic [7:0] read_idle_value        = 8'h00;

  typedef struct packed {
    logic       wrap;
    logic [7:0] position;
  } phase_word_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } host_request_type;
endpackage : phase_monitor_pkg

// *** design/line_to_system_phase_monitor.sv ***
// Line-to-system phase monitor: counts system clocks across each system frame,
// captures the count on each unfrozen line frame pulse, and offers it to a host through a freeze port.
// Assumes both frame pulses arrive as one-cycle pulses already synchronous to clk_sys.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module line_to_system_phase_monitor
  import phase_monitor_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic                          system_frame_pulse,
  input  wire logic                          line_frame_pulse,
  input  wire phase_monitor_pkg::host_request_type host_req,
  output logic [7:0]                         host_rdata,
  output logic                               frozen
);
  import phase_monitor_pkg::*;

  logic [7:0]     position_reg;
  phase_word_type phase_word_reg;
  phase_word_type phase_word_next;
  logic [7:0]     rdata_reg;
  logic [7:0]     rdata_next;
  logic           capture_en;

  // One-hot freeze control; the codes are written out so a stuck or doubled
  // bit shows up plainly on a waveform.
  typedef enum logic [1:0] {
    live_state = 2'b01,
    held_state = 2'b10
  } freeze_state_type;

  freeze_state_type state_reg;
  freeze_state_type state_next;

  // Decoders for the freeze control, the wrap detection and the read path
  function automatic logic is_phase_addr(input logic [7:0] a);
    is_phase_addr = (a == phase_word_low_offset) || (a == phase_word_high_offset);
  endfunction : is_phase_addr

  // Any write to either phase register freezes; the data byte is never looked at
  function automatic logic freeze_request(input host_request_type r);
    freeze_request = r.wr && is_phase_addr(r.addr);
  endfunction : freeze_request

  // Only the low register read lets go, so the high byte must be read first
  function automatic logic release_request(input host_request_type r);
    release_request = r.rd && (r.addr == phase_word_low_offset);
  endfunction : release_request

  // A wrap is a jump between the first and last quarter of the system frame,
  // in either direction; smaller moves are ordinary drift
  function automatic logic crosses_frame(input logic [1:0] prev_q,
                                         input logic [1:0] cur_q);
    crosses_frame = ((prev_q == quadrant_first) && (cur_q == quadrant_last)) ||
                    ((prev_q == quadrant_last) && (cur_q == quadrant_first));
  endfunction : crosses_frame

  // Read multiplexer; unmapped addresses read as the idle value
  function automatic logic [7:0] read_select(input logic [7:0]     a,
                                             input phase_word_type w);
    case (a)
      phase_word_low_offset:  read_select = w.position;
      phase_word_high_offset: read_select = {7'h00, w.wrap};
      default:                read_select = read_idle_value;
    endcase
  endfunction : read_select

  // Capture timing, one line pulse:
  //   cycle 0: system frame pulse, counter cleared at the closing edge
  //   cycle 1: counter reads 0, then climbs by one each cycle
  //   cycle n: line frame pulse sampled while the counter reads n-1
  //   cycle n+1: phase word holds n-1 and the updated wrap bit
  // Host read sequence:
  //   cycle 0: write to either phase register, hold taken at the closing edge
  //   cycle 1: read of the high register
  //   cycle 2: wrap bit on the read data; read of the low register
  //   cycle 3: position on the read data; hold already released

  // Free running between system frames; 8 bits wrap naturally at 255
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      position_reg <= position_reset;
    end else if (system_frame_pulse) begin
      position_reg <= position_reset;
    end else begin
      position_reg <= position_reg + 8'h01;
    end
  end

  // Position is used as is: slot in 7:3, bit in 2:0
  // Drift direction follows directly from capturing raw position
  always_comb begin
    phase_word_next          = phase_word_reg;
    phase_word_next.position = position_reg;
    // Compared against the last capture, not the last pulse, so dropped
    // pulses during a hold cannot fake a wrap
    if (crosses_frame(phase_word_reg.position[7:quadrant_lsb],
                      position_reg[7:quadrant_lsb])) begin
      phase_word_next.wrap = ~phase_word_reg.wrap;
    end
  end

  // The comparison uses the previous capture, so while frozen the wrap history
  // also stands still; a pulse lost during a freeze is simply skipped.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_word_reg <= phase_word_reset;
    end else if (capture_en) begin
      phase_word_reg <= phase_word_next;
    end
  end

  // Freeze control. Live: every unfrozen line pulse refreshes the word.
  // Held: the host owns a stable snapshot until it reads the low byte.
  // A write and a low read never share a cycle, so no priority is needed
  // between them; a second write while held just keeps the hold.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      live_state: begin
        if (freeze_request(host_req)) begin
          state_next = held_state;
        end
      end
      held_state: begin
        if (release_request(host_req)) begin
          state_next = live_state;
        end
      end
      default: begin
        // An illegal code falls back to live rather than locking the word
        state_next = live_state;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= live_state;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pulses that arrive while held are dropped, not queued
  assign capture_en = line_frame_pulse && (state_reg == live_state);

  // Read data stands for one cycle only and is idle otherwise;
  // high before low keeps the pair coherent
  always_comb begin
    rdata_next = read_idle_value;
    if (host_req.rd) begin
      rdata_next = read_select(host_req.addr, phase_word_reg);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= read_idle_value;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign host_rdata = rdata_reg;
  assign frozen     = (state_reg == held_state);
endmodule : line_to_system_phase_monitor
`default_nettype wire

// *** verification/phase_chk_assertions.sv ***
// Checker on the phase monitor ports.
// Bound to the design module below.
`timescale 1ns/1ps
`default_nettype none
module phase_chk
  import phase_monitor_pkg::*;
(
  input wire logic                              clk_sys,
  input wire logic                              rst_n,
  input wire logic                              system_frame_pulse,
  input wire logic                              line_frame_pulse,
  input wire phase_monitor_pkg::host_request_type host_req,
  input wire logic [7:0]                        host_rdata,
  input wire logic                              frozen
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [7:0] cnt_reg;
  logic [8:0] ph_reg;
  wire        wr = host_req.wr && host_req.addr[7:1] == 7'h07;
  wire        rl = host_req.rd && host_req.addr == 8'h0e;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) {ph_reg, cnt_reg} <= 17'h00000;
    else begin
      cnt_reg <= system_frame_pulse ? 8'h00 : cnt_reg + 8'h01;
      if (line_frame_pulse && !frozen) ph_reg <= {ph_reg[8] ^
        ({ph_reg[7:6], cnt_reg[7:6]} inside {4'h3, 4'hc}), cnt_reg};
    end
  sequence s_rh; frozen && host_req.rd && host_req.addr == 8'h0f; endsequence
  property p_f; wr |=> frozen; endproperty
  a_f: assert property (p_f) else $error("no freeze");
  property p_h; frozen && !rl |=> frozen; endproperty
  a_h: assert property (p_h) else $error("freeze lost");
  property p_u; rl |=> !frozen; endproperty
  a_u: assert property (p_u) else $error("no release");
  property p_i; $rose(frozen) |-> $past(wr); endproperty
  a_i: assert property (p_i) else $error("stray freeze");
  property p_z; wr |=> host_rdata == 8'h00; endproperty
  a_z: assert property (p_z) else $error("write echoed");
  property p_r; rl |=> host_rdata == ph_reg[7:0]; endproperty
  a_r: assert property (p_r) else $error("bad low");
  property p_w; s_rh |=> host_rdata == {7'h00, ph_reg[8]}; endproperty
  a_w: assert property (p_w) else $error("bad high");
  property p_n; !host_req.rd |=> host_rdata == 8'h00; endproperty
  a_n: assert property (p_n) else $error("idle data");
endmodule : phase_chk
bind line_to_system_phase_monitor phase_chk u_chk (.*);
`default_nettype wire

// *** verification/host_model.sv ***
// Host processor model on the strobe register port.
// Assumes one access at a time; read data taken at the edge that closes its cycle.
`timescale 1ns/1ps
`default_nettype none
module host_model
  import phase_monitor_pkg::*;
(
  input  wire logic [7:0]                        host_rdata,
  input  wire logic                              clk_sys,
  output var phase_monitor_pkg::host_request_type host_req
);
  initial host_req = '0;
  task automatic xfer(input logic [7:0] a, w, input logic r, output logic [7:0] d);
    @(posedge clk_sys) host_req <= '{a, w, !r, r};
    @(posedge clk_sys) host_req <= '{a, w, 1'b0, 1'b0};
    @(posedge clk_sys) d = host_rdata;
  endtask : xfer
endmodule : host_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Bench: corner and random frame phases, freeze, read high then low.
// Assumes the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import phase_monitor_pkg::*;
  logic clk_sys = 0, rst_n = 0, sfp = 0, lfp = 0;
  logic [7:0] rdata, d, p, corner [6] = '{8'hff, 8'h00, 8'hc0, 8'h3f, 8'h80, 8'h01};
  logic [31:0] lfsr = 32'hbcb1;
  logic [8:0] exp_ph = 9'h000;
  int fail_count = 0, total_checks = 0, cyc = 0;
  host_request_type req;
  logic frz;
  initial forever #2.5 clk_sys = !clk_sys;
  host_model host (.host_rdata(rdata), .clk_sys(clk_sys), .host_req(req));
  line_to_system_phase_monitor DUT (.clk_sys(clk_sys), .rst_n(rst_n), .system_frame_pulse(sfp),
    .line_frame_pulse(lfp), .host_req(req), .host_rdata(rdata), .frozen(frz));
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step
  function automatic logic [8:0] cap(input logic [8:0] q, input logic [7:0] c);
    return {q[8] ^ ({q[7:6], c[7:6]} inside {4'h3, 4'hc}), c};
  endfunction : cap
  task automatic chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Line pulse lands n cycles after the system pulse, so counter reads n-1
  task automatic frame(input int n);
    @(posedge clk_sys) sfp <= 1;
    @(posedge clk_sys) sfp <= 0;
    repeat (n - 1) @(posedge clk_sys);
    lfp <= 1;
    @(posedge clk_sys) lfp <= 0;
  endtask : frame
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_sys) if (++cyc == 20000) begin fail_count++; tally_and_finish; end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1;
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_step(lfsr);
      p = i < 6 ? corner[i] : lfsr[7:0];
      frame(p + 1);
      exp_ph = cap(exp_ph, p);
      host.xfer({7'h07, i[0]}, lfsr[15:8], 1'b0, d);
      chk({7'h00, frz}, 8'h01);
      frame(lfsr[23:16] + 1);
      host.xfer(8'h0f, 8'h00, 1'b1, d);
      chk(d, {7'h00, exp_ph[8]});
      host.xfer(8'h0e, 8'h00, 1'b1, d);
      chk(d, exp_ph[7:0]);
      chk({7'h00, frz}, 8'h00);
      $display("test %0d done", i);
    end
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
